// ==== testbench/rtc_ctrl_sva.sv ====
/*
 port checker for rtc_ctrl.
 assumes single-cycle index and data strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_ctrl_sva(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic power_sense_input_i,
	input wire logic index_wr_i,
	input wire logic data_wr_i,
	input wire logic data_rd_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [7:0] rd_data_o,
	input wire logic irq_o,
	input wire logic update_strobe_o,
	input wire logic hours_24_o,
	input wire logic daylight_en_o
);
	logic [6:0] idx_reg;
	logic [7:0] a_reg;
	logic [7:0] b_reg;
	logic a_ok;
	logic b_ok;
	wire logic set_q = b_ok && b_reg[7];
	wire logic uie_q = b_ok && b_reg[4] && !b_reg[7];
	wire logic rd_a = data_rd_i && idx_reg == 7'h0a;
	wire logic rd_b = data_rd_i && idx_reg == 7'h0b;
	wire logic rd_d = data_rd_i && idx_reg == 7'h0d;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			a_ok <= 1'b0;
			b_ok <= 1'b0;
		end else begin
			if (index_wr_i) begin
				idx_reg <= wr_data_i[6:0];
			end
			if (data_wr_i && idx_reg == 7'h0a) begin
				a_reg <= wr_data_i;
				a_ok <= 1'b1;
			end
			if (data_wr_i && idx_reg == 7'h0b) begin
				b_reg <= wr_data_i;
				b_ok <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_ctl_wr;
		data_wr_i && idx_reg == 7'h0b;
	endsequence
	sequence s_ps_low_rd;
		!power_sense_input_i ##1 rd_d && !power_sense_input_i;
	endsequence
	a_hours_fmt: assert property (s_ctl_wr |=>
		hours_24_o == $past(wr_data_i[1])) else $error("hours bit");
	a_daylight_bit: assert property (s_ctl_wr |=>
		daylight_en_o == $past(wr_data_i[0])) else $error("daylight bit");
	a_flag_unused: assert property (data_rd_i && idx_reg == 7'h0c |=>
		rd_data_o[3:0] == 4'h0) else $error("flag low bits");
	a_valid_unused: assert property (rd_d |=>
		rd_data_o[6:0] == 7'h00) else $error("valid low bits");
	a_valid_forced: assert property (s_ps_low_rd |=>
		rd_data_o[7] == 1'b0) else $error("valid while low");
	a_ctl_readback: assert property (rd_b && b_ok |=>
		{rd_data_o[7:5], rd_data_o[3:0]} ==
		{b_reg[7:5], 2'b00, b_reg[1:0]}) else $error("control read");
	a_rate_readback: assert property (rd_a && a_ok |=>
		rd_data_o[6:0] == a_reg[6:0]) else $error("rate read");
	a_pend_cleared: assert property (rd_a && set_q |=>
		rd_data_o[7] == 1'b0) else $error("pending with inhibit");
	a_no_update: assert property (set_q && $past(set_q) |->
		!update_strobe_o) else $error("update while inhibited");
	a_update_irq: assert property (update_strobe_o && uie_q |->
		##[0:2] irq_o) else $error("update irq missing");
endmodule
bind rtc_ctrl rtc_ctrl_sva sva (.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i), .power_sense_input_i(power_sense_input_i),
	.index_wr_i(index_wr_i), .data_wr_i(data_wr_i), .data_rd_i(data_rd_i),
	.wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
	.update_strobe_o(update_strobe_o), .hours_24_o(hours_24_o),
	.daylight_en_o(daylight_en_o));
`default_nettype wire

// ==== testbench/rtc_host_model.sv ====
/*
 host cpu model making indexed byte cycles.
 assumes read data registered one cycle after the read strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model(
	input wire logic core_clk_i,
	input wire logic [7:0] rd_data_i,
	output logic index_wr_o,
	output logic data_wr_o,
	output logic data_rd_o,
	output logic [7:0] wr_data_o
);
	initial begin
		index_wr_o = 1'b0;
		data_wr_o = 1'b0;
		data_rd_o = 1'b0;
		wr_data_o = 8'h00;
	end
	task automatic xfer(input logic [6:0] i, input logic w,
		input logic [7:0] v, output logic [7:0] q);
		@(posedge core_clk_i);
		index_wr_o <= 1'b1;
		wr_data_o <= {1'b0, i};
		@(posedge core_clk_i);
		index_wr_o <= 1'b0;
		data_wr_o <= w;
		data_rd_o <= !w;
		wr_data_o <= v;
		@(posedge core_clk_i);
		data_wr_o <= 1'b0;
		data_rd_o <= 1'b0;
		// released bus shows the inverse
		wr_data_o <= ~v;
		#1;
		q = rd_data_i;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
 self-checking bench for rtc_ctrl.
 assumes host model and checker compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module tb_top;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic ps_rst_n = 1'b1;
	logic ps_in = 1'b1;
	logic tick = 1'b0;
	logic index_wr, data_wr, data_rd, irq, strobe;
	logic [7:0] wr_data, rd_data, q;
	logic [7:0] t_sec = 8'h12;
	logic [7:0] t_min = 8'h34;
	logic [7:0] t_hour = 8'h05;
	logic hours, dst;
	int cyc = 0;
	int t0;
	int num_errors = 0;
	int cmp_count = 0;
	always #50 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		tick <= (cyc % 4 == 3);
	end
	rtc_ctrl #(.SECOND_CYC(400), .PEND_CYC(20), .UPDATE_CYC(50)) DUT (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
		.power_sense_reset_pin_n_i(ps_rst_n), .power_sense_input_i(ps_in),
		.tick_i(tick), .index_wr_i(index_wr), .data_wr_i(data_wr),
		.data_rd_i(data_rd), .wr_data_i(wr_data), .time_sec_i(t_sec),
		.time_min_i(t_min), .time_hour_i(t_hour), .rd_data_o(rd_data),
		.irq_o(irq), .update_strobe_o(strobe), .hours_24_o(hours),
		.daylight_en_o(dst));
	rtc_host_model host (.core_clk_i(core_clk_i), .rd_data_i(rd_data),
		.index_wr_o(index_wr), .data_wr_o(data_wr), .data_rd_o(data_rd),
		.wr_data_o(wr_data));
	task automatic check(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] i, input logic [7:0] v);
		host.xfer(i, 1'b1, v, q);
	endtask
	task automatic rd(input logic [6:0] i);
		host.xfer(i, 1'b0, 8'h00, q);
	endtask
	task automatic wait_sig(input logic on_irq);
		for (int n = 0; n < 3000; n++) begin
			@(posedge core_clk_i);
			#1;
			if ((on_irq ? irq : strobe) === 1'b1) return;
		end
		check("wait", 16'h1, 16'h0);
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		wr(7'h0e, 8'ha5);
		wr(7'h7f, 8'h5a);
		rd(7'h0e);
		`CHK("ram_0e", 8'ha5, q);
		rd(7'h7f);
		`CHK("ram_7f", 8'h5a, q);
		$display("ram done");
		wr(7'h0b, 8'hc3);
		for (int i = 1; i < 6; i += 2) wr(7'(i), 8'hc0);
		wr(7'h0a, 8'h20);
		rd(7'h0a);
		`CHK("rate_div", 8'h20, q);
		rd(7'h0b);
		`CHK("control", 8'hc3, q);
		`CHK("hours_dst_pins", 2'b11, {hours, dst});
		rd(7'h0c);
		repeat (100) @(posedge core_clk_i);
		rd(7'h0c);
		`CHK("no_flags", 8'h00, q);
		$display("setup done");
		for (int c = 1; c < 10; c++) begin
			wr(7'h0a, 8'h20 | 8'(c));
			rd(7'h0c);
			wait_sig(1'b1);
			t0 = cyc;
			rd(7'h0c);
			`CHK("pf_irq", 8'hc0, q);
			repeat (2) @(posedge core_clk_i);
			wait_sig(1'b1);
			`CHK("period", (c < 3 ? 64 << c : 1 << (c - 1)) * 4, cyc - t0);
		end
		wr(7'h0a, 8'h20);
		rd(7'h0c);
		$display("periodic done");
		wr(7'h0b, 8'h12);
		wait_sig(1'b0);
		rd(7'h0c);
		`CHK("upd_flags", 8'hb0, q);
		rd(7'h0c);
		`CHK("flags_clr", 8'h00, q);
		wr(7'h0b, 8'h92);
		rd(7'h0b);
		`CHK("inhibit_uie", 8'h82, q);
		`CHK("hours_only_pin", 2'b10, {hours, dst});
		wr(7'h0b, 8'h02);
		wait_sig(1'b0);
		@(posedge core_clk_i);
		ps_rst_n <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		ps_rst_n <= 1'b1;
		rd(7'h0c);
		`CHK("pin_clr", 8'h00, q);
		$display("update done");
		@(posedge core_clk_i);
		ps_in <= 1'b0;
		rd(7'h0d);
		`CHK("valid_low", 8'h00, q);
		@(posedge core_clk_i);
		ps_in <= 1'b1;
		rd(7'h0d);
		rd(7'h0d);
		`CHK("valid_set", 8'h80, q);
		wr(7'h0b, 8'hf3);
		@(posedge core_clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		rd(7'h0b);
		`CHK("reset_keep", 8'h83, q);
		$display("reset done");
		finish_test();
	end
	initial begin
		repeat (60000) @(posedge core_clk_i);
		num_errors++;
		finish_test();
	end
endmodule
`default_nettype wire

// ==== verilog/rtc_byte_ram.sv ====
/*
 byte memory for the time, alarm and general bytes of the clock.
 assumes one write or read port, read data registered.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_byte_ram #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic core_clk_i,
	input wire logic clk_en_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wr_data_i,
	output logic [7:0] rd_data_o
);
	logic [7:0] mem_reg [DEPTH];
	logic [7:0] rd_next;

	always_comb begin
		rd_next = mem_reg[addr_i];
	end

	always_ff @(posedge core_clk_i) begin
		if (clk_en_i) begin
			if (wr_en_i) begin
				mem_reg[addr_i] <= wr_data_i;
			end
			rd_data_o <= rd_next;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/rtc_ctrl.sv ====
/*
 control, status and interrupt logic of the clock with its byte ram.
 assumes index writes and data cycles are single-cycle strobes on core_clk_i,
 and a tick input from the 32.768 khz time base.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rtc_ctrl_defs.svh"
module rtc_ctrl #(
	parameter int SECOND_CYC = `SECOND_CYC,
	parameter int PEND_CYC = `PEND_LEAD_CYC,
	parameter int UPDATE_CYC = `UPDATE_CYC
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic power_sense_reset_pin_n_i,
	input wire logic power_sense_input_i,
	input wire logic tick_i,
	input wire logic index_wr_i,
	input wire logic data_wr_i,
	input wire logic data_rd_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [7:0] time_sec_i,
	input wire logic [7:0] time_min_i,
	input wire logic [7:0] time_hour_i,
	output logic [7:0] rd_data_o,
	output logic irq_o,
	output logic update_strobe_o,
	output logic hours_24_o,
	output logic daylight_en_o
);
	logic [6:0] index_reg, index_next;
	logic [3:0] rate_reg, rate_next;
	logic [2:0] div_reg, div_next;
	logic set_reg, set_next;
	logic pie_reg, pie_next;
	logic aie_reg, aie_next;
	logic uie_reg, uie_next;
	logic hr24_reg, hr24_next;
	logic dse_reg, dse_next;
	logic pf_reg, pf_next;
	logic af_reg, af_next;
	logic uf_reg, uf_next;
	logic vrt_reg, vrt_next;
	logic uip_reg, uip_next;
	rtc_ctrl_pkg::upd_state_t st_reg, st_next;
	logic [31:0] sec_cnt_reg, sec_cnt_next;
	logic [31:0] ph_cnt_reg, ph_cnt_next;
	logic [15:0] tick_cnt_reg, tick_cnt_next;
	logic [7:0] reg_rd_next;
	logic [7:0] rd_hold_reg, rd_hold_next;
	logic sel_ram_reg, sel_ram_next;
	logic [7:0] ram_rd;
	logic ram_wr;
	logic in_time;
	logic flags_rd;
	logic set_wr;
	logic upd_done;
	logic per_evt;
	logic alarm_hit;
	logic irq_request_flag;

	// the clock logic writes no byte here; host writes only
	assign in_time = (index_reg <= `IDX_TIME_LAST);
	assign ram_wr = data_wr_i && (index_reg >= `IDX_RAM_FIRST
		|| (in_time && st_reg != rtc_ctrl_pkg::UPD_RUN));

	rtc_byte_ram #(
		.DEPTH(128),
		.AW(7)
	) u_ram (
		.core_clk_i(core_clk_i),
		.clk_en_i(clk_en_i),
		.wr_en_i(ram_wr),
		.addr_i(index_reg),
		.wr_data_i(wr_data_i),
		.rd_data_o(ram_rd)
	);

	// don't-care alarm bytes have both top bits set
	function automatic logic byte_match(input logic [7:0] t,
		input logic [7:0] a);
		byte_match = (a[7:6] == 2'b11) || (a == t);
	endfunction

	// alarm bytes are mirrored by captured writes
	logic [7:0] al_sec_reg, al_sec_next;
	logic [7:0] al_min_reg, al_min_next;
	logic [7:0] al_hour_reg, al_hour_next;

	always_comb begin
		al_sec_next = al_sec_reg;
		al_min_next = al_min_reg;
		al_hour_next = al_hour_reg;
		if (ram_wr && index_reg == 7'h01) begin
			al_sec_next = wr_data_i;
		end else if (ram_wr && index_reg == 7'h03) begin
			al_min_next = wr_data_i;
		end else if (ram_wr && index_reg == 7'h05) begin
			al_hour_next = wr_data_i;
		end
	end

	assign alarm_hit = byte_match(time_sec_i, al_sec_reg)
		&& byte_match(time_min_i, al_min_reg)
		&& byte_match(time_hour_i, al_hour_reg);

	assign flags_rd = data_rd_i && index_reg == `IDX_FLAGS;
	assign set_wr = data_wr_i && index_reg == `IDX_CONTROL
		&& wr_data_i[`B_SET];

	// update sequencer: pending lead, then the update window
	always_comb begin
		st_next = st_reg;
		sec_cnt_next = sec_cnt_reg;
		ph_cnt_next = ph_cnt_reg;
		uip_next = uip_reg;
		upd_done = 1'b0;
		if (div_reg == 3'h0 || set_reg) begin
			sec_cnt_next = 32'h0;
		end else if (sec_cnt_reg >= 32'(SECOND_CYC - 1)) begin
			sec_cnt_next = 32'h0;
		end else begin
			sec_cnt_next = sec_cnt_reg + 32'h1;
		end
		case (st_reg)
		rtc_ctrl_pkg::UPD_IDLE: begin
			if (div_reg != 3'h0 && !set_reg
				&& sec_cnt_reg == 32'(SECOND_CYC - PEND_CYC - 1)) begin
				st_next = rtc_ctrl_pkg::UPD_PEND;
				uip_next = 1'b1;
				ph_cnt_next = 32'h0;
			end
		end
		rtc_ctrl_pkg::UPD_PEND: begin
			ph_cnt_next = ph_cnt_reg + 32'h1;
			if (ph_cnt_reg >= 32'(PEND_CYC - 1)) begin
				st_next = rtc_ctrl_pkg::UPD_RUN;
				ph_cnt_next = 32'h0;
			end
		end
		rtc_ctrl_pkg::UPD_RUN: begin
			ph_cnt_next = ph_cnt_reg + 32'h1;
			if (ph_cnt_reg >= 32'(UPDATE_CYC - 1)) begin
				st_next = rtc_ctrl_pkg::UPD_IDLE;
				uip_next = 1'b0;
				upd_done = 1'b1;
			end
		end
		default: begin
			st_next = rtc_ctrl_pkg::UPD_IDLE;
		end
		endcase
		if (set_reg || set_wr) begin
			st_next = rtc_ctrl_pkg::UPD_IDLE;
			uip_next = 1'b0;
			upd_done = 1'b0;
		end
	end

	// periodic tap: rate n divides the 32.768 khz tick by 2^(n-1) for n of 3 and up; rates 1 and 2 divide by 128 and 256
	always_comb begin
		tick_cnt_next = tick_cnt_reg;
		per_evt = 1'b0;
		if (tick_i && div_reg != 3'h0) begin
			tick_cnt_next = tick_cnt_reg + 16'h1;
			if (rate_reg == 4'h1) begin
				per_evt = (tick_cnt_reg[6:0] == 7'h7f);
			end else if (rate_reg == 4'h2) begin
				per_evt = (tick_cnt_reg[7:0] == 8'hff);
			end else if (rate_reg != 4'h0) begin
				per_evt = &(tick_cnt_reg | ~((16'h1 << (rate_reg - 4'h1))
					- 16'h1));
			end
		end
	end

	// control fields and flags
	always_comb begin
		rate_next = rate_reg;
		div_next = div_reg;
		set_next = set_reg;
		pie_next = pie_reg;
		aie_next = aie_reg;
		uie_next = uie_reg;
		hr24_next = hr24_reg;
		dse_next = dse_reg;
		vrt_next = vrt_reg;
		if (data_wr_i && index_reg == `IDX_RATE_DIV) begin
			rate_next = wr_data_i[`A_RS_HI:0];
			div_next = wr_data_i[`A_DIV_HI:`A_DIV_LO];
		end else if (data_wr_i && index_reg == `IDX_CONTROL) begin
			set_next = wr_data_i[`B_SET];
			pie_next = wr_data_i[`B_PIE];
			aie_next = wr_data_i[`B_AIE];
			uie_next = wr_data_i[`B_UIE] && !wr_data_i[`B_SET];
			hr24_next = wr_data_i[`B_HR24];
			dse_next = wr_data_i[`B_DSE];
		end
		// valid flag: only a read of the fourth register sets it
		if (data_rd_i && index_reg == `IDX_VALID) begin
			vrt_next = 1'b1;
		end
		if (!power_sense_input_i) begin
			vrt_next = 1'b0;
		end
		// read clears; a same-cycle set survives
		pf_next = (pf_reg && !flags_rd) || per_evt;
		af_next = (af_reg && !flags_rd) || (upd_done && alarm_hit);
		uf_next = (uf_reg && !flags_rd) || upd_done;
		if (!power_sense_reset_pin_n_i) begin
			pf_next = 1'b0;
			af_next = 1'b0;
			uf_next = 1'b0;
		end
	end

	assign irq_request_flag = (pf_reg && pie_reg) || (af_reg && aie_reg)
		|| (uf_reg && uie_reg);

	// register read mux; unused bits are zero
	always_comb begin
		reg_rd_next = 8'h00;
		sel_ram_next = 1'b0;
		rd_hold_next = rd_hold_reg;
		if (index_reg == `IDX_RATE_DIV) begin
			reg_rd_next = {uip_reg, div_reg, rate_reg};
		end else if (index_reg == `IDX_CONTROL) begin
			reg_rd_next = {set_reg, pie_reg, aie_reg, uie_reg, 2'b00,
				hr24_reg, dse_reg};
		end else if (index_reg == `IDX_FLAGS) begin
			reg_rd_next = {irq_request_flag, pf_reg, af_reg, uf_reg, 4'h0};
		end else if (index_reg == `IDX_VALID) begin
			reg_rd_next = {vrt_reg, 7'h00};
		end else begin
			sel_ram_next = 1'b1;
		end
		if (data_rd_i) begin
			rd_hold_next = reg_rd_next;
		end
	end

	always_comb begin
		index_next = index_reg;
		if (index_wr_i) begin
			index_next = wr_data_i[6:0];
		end
	end

	// interrupt flags, enables and the tick counter cleared by reset; format bits, valid flag and sequencer state kept
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pie_reg <= 1'b0;
			aie_reg <= 1'b0;
			uie_reg <= 1'b0;
			pf_reg <= 1'b0;
			af_reg <= 1'b0;
			uf_reg <= 1'b0;
			tick_cnt_reg <= 16'h0000;
		end else if (clk_en_i) begin
			tick_cnt_reg <= tick_cnt_next;
			pie_reg <= pie_next;
			aie_reg <= aie_next;
			uie_reg <= uie_next;
			pf_reg <= pf_next;
			af_reg <= af_next;
			uf_reg <= uf_next;
		end
	end

	// reset-immune state: no async reset here
	always_ff @(posedge core_clk_i) begin
		if (clk_en_i) begin
			set_reg <= set_next;
			hr24_reg <= hr24_next;
			dse_reg <= dse_next;
			uip_reg <= uip_next;
			vrt_reg <= vrt_next;
			rate_reg <= rate_next;
			div_reg <= div_next;
			st_reg <= st_next;
			sec_cnt_reg <= sec_cnt_next;
			ph_cnt_reg <= ph_cnt_next;
			index_reg <= index_next;
			al_sec_reg <= al_sec_next;
			al_min_reg <= al_min_next;
			al_hour_reg <= al_hour_next;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_hold_reg <= 8'h00;
			sel_ram_reg <= 1'b0;
			irq_o <= 1'b0;
			update_strobe_o <= 1'b0;
		end else if (clk_en_i) begin
			rd_hold_reg <= rd_hold_next;
			sel_ram_reg <= sel_ram_next;
			irq_o <= irq_request_flag;
			update_strobe_o <= upd_done;
		end
	end

	assign rd_data_o = sel_ram_reg ? ram_rd : rd_hold_reg;
	assign hours_24_o = hr24_reg;
	assign daylight_en_o = dse_reg;
endmodule
`default_nettype wire

// ==== verilog/rtc_ctrl_defs.svh ====
/*
 holds index map, field positions, reset values and timing counts of the
 clock control block. assumes a 10 mhz core clock.
*/
`ifndef RTC_CTRL_DEFS_SVH
`define RTC_CTRL_DEFS_SVH

`define IDX_RATE_DIV 7'h0a
`define IDX_CONTROL 7'h0b
`define IDX_FLAGS 7'h0c
`define IDX_VALID 7'h0d
`define IDX_RAM_FIRST 7'h0e
`define IDX_TIME_LAST 7'h09

`define A_UIP 7
`define A_DIV_HI 6
`define A_DIV_LO 4
`define A_RS_HI 3
`define B_SET 7
`define B_PIE 6
`define B_AIE 5
`define B_UIE 4
`define B_HR24 1
`define B_DSE 0
`define C_IRQ_REQUEST_FLAG 7
`define C_PF 6
`define C_AF 5
`define C_UF 4
`define D_VRT 7

`define RATE_RESET 4'h6
`define DIV_RESET 3'h2
`define DIV_NORMAL 3'h2
`define CONTROL_RESET 8'h02

`define CLK_HZ 10000000
`define TICK_HZ 32768
`define PEND_LEAD_US 244
`define UPDATE_US 2000
`define PEND_LEAD_CYC ((`PEND_LEAD_US * `CLK_HZ) / 1000000)
`define UPDATE_CYC ((`UPDATE_US * `CLK_HZ) / 1000000)
`define SECOND_CYC `CLK_HZ

`endif

// ==== verilog/rtc_ctrl_pkg.sv ====
/*
 types for the clock control block. stands alone.
*/
package rtc_ctrl_pkg;
	typedef enum logic [2:0] {
		UPD_IDLE = 3'b001,
		UPD_PEND = 3'b010,
		UPD_RUN = 3'b100
	} upd_state_t;
endpackage
